/* bench/e1_receive_sync_control_test.sv */
// testbench: host port, line events and alignment checks
module e1_receive_sync_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========
    // constants and signals
    localparam logic FAM = 1'h1;
    localparam logic [3:0] REV = 4'h7; // arbitrary value
    localparam int MFW = 50;
    localparam logic [7:0] RC1 = e1rs_pkg::ADDR_RX_CTRL_ONE;
    localparam logic [7:0] RC2 = e1rs_pkg::ADDR_RX_CTRL_TWO;
    logic clk_sys = 1'h0;
    logic rst_b, csB, rdB, wrB, lineLevel, pinWire, dataOe, pinOut, pinOe;
    logic toStore, linkClk, rateSel, esEn, frameSync, crcMfSync, casMfSync;
    logic [7:0] addr, dataIn, dataOut, txCtrlOne, rd;
    logic [14:0] ev;
    int error_cnt = 0;
    int n_tests = 0;
    int bndCnt = 0;
    int lnkCnt = 0;
    int b0;
    logic [23:0] rows [7] = '{24'h11fafa, 24'h10e4e4, 24'h100000,
        24'h110000, 24'h12a5a5, {16'h0fff, FAM, 3'h0, REV}, 24'h205a00};
    // ==========
    // clock, pin wire and pulse counters
    always #10 clk_sys = ~clk_sys;
    assign pinWire = pinOe ? pinOut : lineLevel;
    always @(posedge clk_sys) begin
        bndCnt <= bndCnt + int'(pinOut);
        lnkCnt <= lnkCnt + int'(linkClk);
    end
    // line side and design
    e1rs_line_model line_u (
        .clk_sys(clk_sys),
        .ev(ev),
        .lineLevel(lineLevel)
    );
    e1rs_rx_sync_ctrl #(
        .DIE_REVISION(REV),
        .MF_WIN_CYC(MFW)
    ) dut_u (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .csB(csB),
        .rdB(rdB),
        .wrB(wrB),
        .addr(addr),
        .dataIn(dataIn),
        .dataOut(dataOut),
        .dataOe(dataOe),
        .frameStb(ev[14]),
        .fasFound(ev[13]),
        .nfasBit2(ev[12]),
        .crcMfawStb(ev[11]),
        .crcMfStb(ev[10]),
        .crcWordStb(ev[9]),
        .crcWordErr(ev[8]),
        .casMfawStb(ev[7]),
        .casMfawErr(ev[6]),
        .ts16Zero(ev[5]),
        .spareBitPos(ev[4:0]),
        .rx_boundary_pin_in(pinWire),
        .rx_boundary_pin_out(pinOut),
        .rx_boundary_pin_oe(pinOe),
        .boundaryToStore(toStore),
        .rx_link_clock(linkClk),
        .backplane_rate_sel(rateSel),
        .rx_elastic_buffer_enable(esEn),
        .frameSync(frameSync),
        .crcMfSync(crcMfSync),
        .casMfSync(casMfSync),
        .txCtrlOne(txCtrlOne)
    );
    // ==========
    // compare the values taken at the call, two cycles later
    task automatic check(input string nm, input logic [7:0] seen,
        input logic [7:0] exp);
        repeat (2) @(negedge clk_sys);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // host write, strobes held past the sync delay
    task automatic hostWr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        addr = a;
        dataIn = d;
        csB = 1'h0;
        wrB = 1'h0;
        repeat (4) @(negedge clk_sys);
        wrB = 1'h1;
        repeat (4) @(negedge clk_sys);
        csB = 1'h1;
        repeat (3) @(negedge clk_sys);
    endtask : hostWr
    // host read, data taken while strobes still low
    task automatic hostRd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        addr = a;
        csB = 1'h0;
        rdB = 1'h0;
        repeat (4) @(negedge clk_sys);
        check("dataOe", 8'(dataOe), 8'h01);
        d = dataOut;
        csB = 1'h1;
        rdB = 1'h1;
        repeat (4) @(negedge clk_sys);
    endtask : hostRd
    // line events
    task automatic frame(input logic f, input logic n);
        line_u.pulse({1'h1, f, n, 12'h000});
    endtask : frame
    task automatic cas(input logic e, input logic z);
        line_u.pulse({8'h01, e, z, 5'h00});
    endtask : cas
    task automatic crcRound(input int nErr);
        for (int i = 0; i < 1000; i++) begin
            line_u.pulse({6'h01, 1'(i < nErr), 8'h00});
        end
    endtask : crcRound
    task automatic align();
        frame(1'h0, 1'h1);
        frame(1'h1, 1'h1);
        frame(1'h0, 1'h1);
        frame(1'h1, 1'h1);
    endtask : align
    // good nfas, errored fas, three times
    task automatic lose3();
        repeat (3) begin
            frame(1'h0, 1'h1);
            frame(1'h0, 1'h1);
        end
    endtask : lose3
    // counts and verdict
    task automatic summarize();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    // ==========
    // watchdog
    initial begin
        repeat (40000) @(posedge clk_sys);
        error_cnt++;
        summarize();
    end
    // main sequence
    initial begin
        rst_b = 1'h0;
        csB = 1'h1;
        rdB = 1'h1;
        wrB = 1'h1;
        addr = 8'h00;
        dataIn = 8'h00;
        repeat (5) @(negedge clk_sys);
        rst_b = 1'h1;
        // first edge after release sets the pin direction
        @(negedge clk_sys);
        check("pinOe", 8'(pinOe), 8'h01);
        check("frameSync", 8'(frameSync), 8'h00);
        for (int a = 0; a < 192; a++) hostWr(8'(a), 8'h00);
        foreach (rows[i]) begin
            hostWr(rows[i][23:16], rows[i][15:8]);
            hostRd(rows[i][23:16], rd);
            check("readback", rd, rows[i][7:0]);
        end
        check("txCtrlOne", txCtrlOne, 8'ha5);
        align();
        check("frameSync", 8'(frameSync), 8'h01);
        repeat (3) begin
            frame(1'h0, 1'h0);
            frame(1'h1, 1'h1);
        end
        check("frameSync", 8'(frameSync), 8'h01);
        hostWr(RC1, 8'h04);
        repeat (3) begin
            frame(1'h0, 1'h0);
            frame(1'h1, 1'h1);
        end
        check("frameSync", 8'(frameSync), 8'h00);
        align();
        check("frameSync", 8'(frameSync), 8'h01);
        hostWr(RC1, 8'h02);
        lose3();
        check("frameSync", 8'(frameSync), 8'h00);
        align();
        check("frameSync", 8'(frameSync), 8'h00);
        hostWr(RC1, 8'h03);
        align();
        check("frameSync", 8'(frameSync), 8'h01);
        lose3();
        hostWr(RC1, 8'h03);
        align();
        check("frameSync", 8'(frameSync), 8'h00);
        hostWr(RC1, 8'h02);
        hostWr(RC1, 8'h03);
        align();
        check("frameSync", 8'(frameSync), 8'h01);
        // cas multiframe mode
        hostWr(RC1, 8'h43);
        b0 = bndCnt;
        frame(1'h0, 1'h1);
        frame(1'h1, 1'h1);
        check("bndPulses", 8'(bndCnt - b0), 8'h00);
        cas(1'h0, 1'h1);
        check("casMfSync", 8'(casMfSync), 8'h00);
        // aligning word gives no pulse, the next good word does
        b0 = bndCnt;
        cas(1'h0, 1'h0);
        check("casMfSync", 8'(casMfSync), 8'h01);
        cas(1'h0, 1'h0);
        check("bndPulses", 8'(bndCnt - b0), 8'h01);
        cas(1'h1, 1'h0);
        check("casMfSync", 8'(casMfSync), 8'h01);
        cas(1'h1, 1'h0);
        check("casMfSync", 8'(casMfSync), 8'h00);
        hostWr(RC1, 8'h03);
        b0 = bndCnt;
        frame(1'h0, 1'h1);
        frame(1'h1, 1'h1);
        check("bndPulses", 8'(bndCnt - b0), 8'h02);
        // crc4 multiframe mode
        hostWr(RC1, 8'hc3);
        line_u.pulse(15'h0800);
        repeat (80) @(negedge clk_sys);
        line_u.pulse(15'h0800);
        check("crcMfSync", 8'(crcMfSync), 8'h00);
        line_u.pulse(15'h0800);
        check("crcMfSync", 8'(crcMfSync), 8'h01);
        b0 = bndCnt;
        line_u.pulse(15'h0400);
        check("bndPulses", 8'(bndCnt - b0), 8'h01);
        crcRound(914);
        check("crcMfSync", 8'(crcMfSync), 8'h01);
        crcRound(915);
        check("crcMfSync", 8'(crcMfSync), 8'h00);
        // elastic store, rate and pin direction
        hostWr(RC2, 8'h06);
        check("rateSel", 8'(rateSel), 8'h01);
        check("esEn", 8'(esEn), 8'h01);
        hostWr(RC1, 8'h23);
        check("pinOe", 8'(pinOe), 8'h00);
        line_u.setLevel(1'h1);
        check("toStore", 8'(toStore), 8'h01);
        line_u.setLevel(1'h0);
        check("toStore", 8'(toStore), 8'h00);
        hostWr(RC1, 8'h03);
        check("pinOe", 8'(pinOe), 8'h01);
        hostWr(RC2, 8'h00);
        check("rateSel", 8'(rateSel), 8'h00);
        check("esEn", 8'(esEn), 8'h00);
        // one spare select at a time against every position
        for (int k = 0; k < 5; k++) begin
            hostWr(RC2, 8'(8'h08 << k));
            for (int j = 0; j < 5; j++) begin
                b0 = lnkCnt;
                line_u.pulse(15'(1 << j));
                check("linkClk", 8'(lnkCnt - b0), 8'(j == k));
            end
        end
        summarize();
    end
endmodule : e1_receive_sync_control_test

/* bench/e1rs_line_model.sv */
// line side model: receive path event strobes and pin level
module e1rs_line_model (
    input wire logic clk_sys,
    output logic [14:0] ev,
    output logic lineLevel
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========
    // idle strobes and a low pin level at start
    initial begin
        ev = 15'h0000;
        lineLevel = 1'h0;
    end
    // one strobe cycle, then idle until the pulse counters settle
    task automatic pulse(input logic [14:0] v);
        @(negedge clk_sys);
        ev = v;
        @(negedge clk_sys);
        ev = 15'h0000;
        @(negedge clk_sys);
    endtask : pulse
    // far end drives the boundary pin level
    task automatic setLevel(input logic v);
        @(negedge clk_sys);
        lineLevel = v;
        // two sync stages before the level shows inside
        repeat (2) @(negedge clk_sys);
    endtask : setLevel
endmodule : e1rs_line_model

/* logic/e1rs_crc_monitor.sv */
// crc4 code word error window: loss after too many errored words
module e1rs_crc_monitor (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic wordStb,
    input wire logic wordErr,
    output logic lossStb
);
    logic [9:0] wordCnt_r;
    logic [9:0] errCnt_r;
    logic [9:0] errNxt;
    logic lastWord;

    // running error total including this word
    assign errNxt = errCnt_r + 10'(wordErr);
    assign lastWord = (wordCnt_r == e1rs_pkg::CRC_WORDS - 10'h001);

    // =================================================================
    // count words and errors over each window
    always_ff @(posedge clk_sys) begin
        if (!rst_b || !enable) begin
            wordCnt_r <= 10'h000;
            errCnt_r <= 10'h000;
        end else if (wordStb) begin
            wordCnt_r <= lastWord ? 10'h000 : wordCnt_r + 10'h001;
            errCnt_r <= lastWord ? 10'h000 : errNxt;
        end
    end

    // loss pulse at window end
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            lossStb <= 1'b0;
        end else begin
            lossStb <= enable && wordStb && lastWord &&
                (errNxt >= e1rs_pkg::CRC_ERR_LIMIT);
        end
    end
endmodule : e1rs_crc_monitor

/* logic/e1rs_pkg.sv */
// package: register map, field positions and timing for e1 receive sync
// =====================================================================
// Contract
// - id top bit flags family, 6:4 zero
// - id low nibble holds decimal die revision
// - pulse mode clear frames, set multiframes
// - multiframe kind clear cas, set crc4
// - direction clear output, set input
// - three errored fas, optionally nfas bit2
// - auto realign disable bit stops hunting
// - manual bit rising edge starts one realign
// - fas in n, absent n+1, present n+2
// - two crc4 mfaw within 8 ms aligns
// - 915 of 1000 crc4 words errored loses
// - two errored cas mfaw lose alignment
// - spare select bits gate link clock pulses
// - rate bit selects 1.544 or 2.048 backplane
// - elastic bit bypasses or inserts store
package e1rs_pkg;
    // =================================================================
    // register offsets
    localparam logic [7:0] ADDR_CHIP_IDENTITY = 8'h0f;
    localparam logic [7:0] ADDR_RX_CTRL_ONE = 8'h10;
    localparam logic [7:0] ADDR_RX_CTRL_TWO = 8'h11;
    localparam logic [7:0] ADDR_TX_CTRL_ONE = 8'h12;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // =================================================================
    // field positions
    localparam int ID_FAMILY_POS = 7;
    localparam int RC1_MF_KIND = 7;
    localparam int RC1_PULSE_MODE = 6;
    localparam int RC1_SYNC_DIR = 5;
    localparam int RC1_CRITERIA = 2;
    localparam int RC1_AUTO_DIS = 1;
    localparam int RC1_MANUAL = 0;
    localparam int RC2_SPARE_LO = 3;
    localparam int RC2_RATE = 2;
    localparam int RC2_ELASTIC = 1;
    // =================================================================
    // alignment limits and timing
    localparam logic [1:0] FAS_ERR_LIMIT = 2'h3;
    localparam logic [1:0] CAS_ERR_LIMIT = 2'h2;
    localparam logic [9:0] CRC_WORDS = 10'h3e8;
    localparam logic [9:0] CRC_ERR_LIMIT = 10'h393;
    localparam int MF_WIN_MS = 8;
    localparam int CLK_KHZ = 50000;
    localparam int MF_WIN_CYC = MF_WIN_MS * CLK_KHZ;
endpackage : e1rs_pkg

/* logic/e1rs_rx_sync_ctrl.sv */
// receive control registers and frame/multiframe alignment
module e1rs_rx_sync_ctrl #(
    parameter logic FAMILY_E1 = 1'b1,
    parameter logic [3:0] DIE_REVISION = 4'h1, // arbitrary value
    parameter int MF_WIN_CYC = e1rs_pkg::MF_WIN_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    // parallel host port, intel style, non multiplexed
    input wire logic csB,
    input wire logic rdB,
    input wire logic wrB,
    input wire logic [7:0] addr,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOe,
    // receive path events, one cycle each
    input wire logic frameStb,
    input wire logic fasFound,
    input wire logic nfasBit2,
    input wire logic crcMfawStb,
    input wire logic crcMfStb,
    input wire logic crcWordStb,
    input wire logic crcWordErr,
    input wire logic casMfawStb,
    input wire logic casMfawErr,
    input wire logic ts16Zero,
    input wire logic [4:0] spareBitPos,
    // boundary pin, three signals
    input wire logic rx_boundary_pin_in,
    output logic rx_boundary_pin_out,
    output logic rx_boundary_pin_oe,
    output logic boundaryToStore,
    output logic rx_link_clock,
    output logic backplane_rate_sel,
    output logic rx_elastic_buffer_enable,
    output logic frameSync,
    output logic crcMfSync,
    output logic casMfSync,
    output logic [7:0] txCtrlOne
);
    typedef enum logic [2:0] {
        FR_HUNT, FR_NOFAS, FR_FAS2, FR_SYNC, FR_LOST
    } e1rs_frame_t;
    typedef enum logic [1:0] {CRC_HUNT, CRC_WAIT, CRC_SYNC} e1rs_crc_t;

    logic [7:0] rxCtrlOne_r;
    logic [7:0] rxCtrlTwo_r;
    logic [7:0] txCtrlOne_r;
    logic [19:0] pinSync;
    logic csAct;
    logic rdAct;
    logic wrSync;
    logic wrPrev_r;
    logic wrStb;
    logic [7:0] addrSync;
    logic [7:0] dataSync;
    logic boundInSync;
    logic manualPrev_r;
    logic manualRise;
    e1rs_frame_t frState_r;
    logic fasFrame_r;
    logic [1:0] fasErr_r;
    logic [1:0] nfasErr_r;
    logic frameLoss;
    e1rs_crc_t crcState_r;
    logic [19:0] mfTimer_r;
    logic crcLoss;
    logic [1:0] casErr_r;
    logic casSync_r;
    logic boundOut_r;
    logic boundOe_r;
    logic linkClk_r;
    logic [7:0] rdData;

    // =================================================================
    // host port pins through two flip-flops
    e1rs_sync2 #(.WIDTH(20)) uPinSync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pinIn({rx_boundary_pin_in, dataIn, addr, wrB, rdB, csB}),
        .pinSync(pinSync)
    );

    assign csAct = !pinSync[0];
    assign rdAct = csAct && !pinSync[1];
    assign wrSync = pinSync[2];
    assign addrSync = pinSync[10:3];
    assign dataSync = pinSync[18:11];
    assign boundInSync = pinSync[19];
    // write completes on the rising edge of the write strobe
    assign wrStb = csAct && wrSync && !wrPrev_r;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wrPrev_r <= 1'b1;
        end else begin
            wrPrev_r <= wrSync;
        end
    end

    // =================================================================
    // control registers, identity ignores writes
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rxCtrlOne_r <= e1rs_pkg::CTRL_RESET;
            rxCtrlTwo_r <= e1rs_pkg::CTRL_RESET;
            txCtrlOne_r <= e1rs_pkg::CTRL_RESET;
        end else if (wrStb) begin
            unique case (addrSync)
                e1rs_pkg::ADDR_RX_CTRL_ONE: rxCtrlOne_r <= dataSync;
                e1rs_pkg::ADDR_RX_CTRL_TWO: rxCtrlTwo_r <= dataSync;
                e1rs_pkg::ADDR_TX_CTRL_ONE: txCtrlOne_r <= dataSync;
                default: ;
            endcase
        end
    end

    // read multiplexer, unmapped locations read zero
    always_comb begin
        rdData = 8'h00;
        unique case (addrSync)
            e1rs_pkg::ADDR_CHIP_IDENTITY: begin
                rdData[e1rs_pkg::ID_FAMILY_POS] = FAMILY_E1;
                rdData[3:0] = DIE_REVISION;
            end
            e1rs_pkg::ADDR_RX_CTRL_ONE: rdData = rxCtrlOne_r;
            e1rs_pkg::ADDR_RX_CTRL_TWO: rdData = rxCtrlTwo_r;
            e1rs_pkg::ADDR_TX_CTRL_ONE: rdData = txCtrlOne_r;
            default: rdData = 8'h00;
        endcase
    end

    // read data and bus drive registered
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            dataOut <= 8'h00;
            dataOe <= 1'b0;
        end else begin
            dataOe <= rdAct;
            if (rdAct) begin
                dataOut <= rdData;
            end
        end
    end

    // =================================================================
    // manual realign edge detect
    assign manualRise = rxCtrlOne_r[e1rs_pkg::RC1_MANUAL] && !manualPrev_r;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            manualPrev_r <= 1'b0;
        end else begin
            manualPrev_r <= rxCtrlOne_r[e1rs_pkg::RC1_MANUAL];
        end
    end

    // loss of frame alignment from consecutive errors
    assign frameLoss = (frState_r == FR_SYNC) && frameStb && (fasFrame_r ?
        (!fasFound && fasErr_r == e1rs_pkg::FAS_ERR_LIMIT - 2'h1) :
        (rxCtrlOne_r[e1rs_pkg::RC1_CRITERIA] && !nfasBit2 &&
         nfasErr_r == e1rs_pkg::FAS_ERR_LIMIT - 2'h1));

    // =================================================================
    // frame alignment search and hold
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            frState_r <= FR_HUNT;
        end else if (manualRise) begin
            frState_r <= FR_HUNT;
        end else if (frameStb) begin
            unique case (frState_r)
                FR_HUNT: if (fasFound) frState_r <= FR_NOFAS;
                FR_NOFAS: if (fasFound) frState_r <= FR_NOFAS;
                          else frState_r <= FR_FAS2;
                FR_FAS2: frState_r <= fasFound ? FR_SYNC : FR_HUNT;
                FR_SYNC: if (frameLoss) begin
                    frState_r <= rxCtrlOne_r[e1rs_pkg::RC1_AUTO_DIS] ?
                        FR_LOST : FR_HUNT;
                end
                FR_LOST: frState_r <= FR_LOST;
            endcase
        end
    end

    // fas/nfas phase and consecutive error counts
    always_ff @(posedge clk_sys) begin
        if (!rst_b || frState_r != FR_SYNC) begin
            fasFrame_r <= 1'b0;
            fasErr_r <= 2'h0;
            nfasErr_r <= 2'h0;
        end else if (frameStb) begin
            fasFrame_r <= !fasFrame_r;
            if (fasFrame_r) begin
                fasErr_r <= fasFound ? 2'h0 : fasErr_r + 2'h1;
            end else begin
                // counts only while the criteria bit is on, so no wrap
                nfasErr_r <= (nfasBit2 ||
                    !rxCtrlOne_r[e1rs_pkg::RC1_CRITERIA]) ?
                    2'h0 : nfasErr_r + 2'h1;
            end
        end
    end

    assign frameSync = (frState_r == FR_SYNC);

    // =================================================================
    // crc4 multiframe alignment
    e1rs_crc_monitor uCrcMon (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .enable(crcState_r == CRC_SYNC),
        .wordStb(crcWordStb),
        .wordErr(crcWordErr),
        .lossStb(crcLoss)
    );

    always_ff @(posedge clk_sys) begin
        if (!rst_b || !frameSync) begin
            crcState_r <= CRC_HUNT;
            mfTimer_r <= 20'h00000;
        end else begin
            unique case (crcState_r)
                CRC_HUNT: begin
                    mfTimer_r <= 20'h00000;
                    if (crcMfawStb) crcState_r <= CRC_WAIT;
                end
                CRC_WAIT: begin
                    mfTimer_r <= mfTimer_r + 20'h00001;
                    if (crcMfawStb) begin
                        crcState_r <= CRC_SYNC;
                    end else if (mfTimer_r >= 20'(MF_WIN_CYC - 1)) begin
                        crcState_r <= CRC_HUNT;
                    end
                end
                CRC_SYNC: if (crcLoss) crcState_r <= CRC_HUNT;
            endcase
        end
    end

    assign crcMfSync = (crcState_r == CRC_SYNC);

    // =================================================================
    // cas multiframe alignment
    always_ff @(posedge clk_sys) begin
        if (!rst_b || !frameSync) begin
            casSync_r <= 1'b0;
            casErr_r <= 2'h0;
        end else if (casMfawStb) begin
            if (!casSync_r) begin
                casSync_r <= !casMfawErr && !ts16Zero;
                casErr_r <= 2'h0;
            end else if (!casMfawErr) begin
                casErr_r <= 2'h0;
            end else if (casErr_r == e1rs_pkg::CAS_ERR_LIMIT - 2'h1) begin
                casSync_r <= 1'b0;
                casErr_r <= 2'h0;
            end else begin
                casErr_r <= casErr_r + 2'h1;
            end
        end
    end

    assign casMfSync = casSync_r;

    // =================================================================
    // boundary pin: frame or multiframe pulses, or input
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            boundOut_r <= 1'b0;
            boundOe_r <= 1'b0;
        end else begin
            boundOe_r <= !rxCtrlOne_r[e1rs_pkg::RC1_SYNC_DIR];
            if (!rxCtrlOne_r[e1rs_pkg::RC1_PULSE_MODE]) begin
                boundOut_r <= frameStb && frameSync;
            end else if (rxCtrlOne_r[e1rs_pkg::RC1_MF_KIND]) begin
                boundOut_r <= crcMfStb && crcMfSync;
            end else begin
                boundOut_r <= casMfawStb && casSync_r && !casMfawErr;
            end
        end
    end

    assign rx_boundary_pin_out = boundOut_r;
    assign rx_boundary_pin_oe = boundOe_r;
    // input use only with the elastic store present
    assign boundaryToStore = boundInSync && !boundOe_r &&
        rxCtrlTwo_r[e1rs_pkg::RC2_ELASTIC];

    // =================================================================
    // link clock gated per spare bit position
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            linkClk_r <= 1'b0;
        end else begin
            linkClk_r <= |(spareBitPos &
                rxCtrlTwo_r[e1rs_pkg::RC2_SPARE_LO +: 5]);
        end
    end

    assign rx_link_clock = linkClk_r;
    assign backplane_rate_sel = rxCtrlTwo_r[e1rs_pkg::RC2_RATE];
    assign rx_elastic_buffer_enable =
        rxCtrlTwo_r[e1rs_pkg::RC2_ELASTIC];
    assign txCtrlOne = txCtrlOne_r;

    // =================================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_ctrl_write;
        wrStb && addrSync == e1rs_pkg::ADDR_RX_CTRL_TWO;
    endsequence
    sequence s_ctrl_read;
        rdAct && addrSync == e1rs_pkg::ADDR_RX_CTRL_TWO;
    endsequence

    a_id_family: assert property (
        rdAct && addrSync == e1rs_pkg::ADDR_CHIP_IDENTITY |=>
        dataOut[7:4] == {FAMILY_E1, 3'h0})
        else $error("identity upper bits wrong");
    a_id_revision: assert property (
        rdAct && addrSync == e1rs_pkg::ADDR_CHIP_IDENTITY |=>
        dataOut[3:0] == DIE_REVISION)
        else $error("identity revision wrong");
    a_pin_frame_mode: assert property (
        frameStb && frameSync && !rxCtrlOne_r[e1rs_pkg::RC1_PULSE_MODE]
        |=> boundOut_r)
        else $error("frame boundary pulse missing");
    a_pin_crc_kind: assert property (
        crcMfStb && crcMfSync && rxCtrlOne_r[7:6] == 2'h3 |=> boundOut_r)
        else $error("crc4 boundary pulse missing");
    a_pin_direction: assert property (
        rxCtrlOne_r[e1rs_pkg::RC1_SYNC_DIR] |=> !rx_boundary_pin_oe)
        else $error("boundary pin driven in input mode");
    a_fas_loss: assert property (
        frameSync && frameStb && fasFrame_r && !fasFound &&
        fasErr_r == 2'h2 |=> !frameSync)
        else $error("third errored fas kept alignment");
    a_auto_off: assert property (
        frameLoss && rxCtrlOne_r[e1rs_pkg::RC1_AUTO_DIS] && !manualRise
        |=> frState_r == FR_LOST)
        else $error("hunt started with auto realign off");
    a_manual_edge: assert property (
        $rose(rxCtrlOne_r[e1rs_pkg::RC1_MANUAL]) |=> frState_r == FR_HUNT)
        else $error("manual realign not started");
    a_frame_align: assert property (
        frState_r == FR_FAS2 && frameStb && fasFound && !manualRise
        |=> frameSync)
        else $error("frame alignment not declared");
    a_crc_align: assert property (
        crcState_r == CRC_WAIT && crcMfawStb && frameSync |=> crcMfSync)
        else $error("crc4 alignment not declared");
    a_crc_loss: assert property (
        crcLoss && frameSync |=> !crcMfSync)
        else $error("crc4 loss ignored");
    a_cas_align: assert property (
        frameSync && casMfawStb && !casMfawErr && !ts16Zero |=> casMfSync)
        else $error("cas alignment not declared");
    a_link_clock: assert property (
        |(spareBitPos & rxCtrlTwo_r[7:3]) |=> rx_link_clock)
        else $error("link clock pulse missing");
    a_read_back: assert property (
        s_ctrl_write |=> rxCtrlTwo_r == $past(dataSync))
        else $error("control register write lost");
    a_read_data: assert property (
        s_ctrl_read |=> dataOut == $past(rxCtrlTwo_r))
        else $error("control register read back wrong");
endmodule : e1rs_rx_sync_ctrl

/* logic/e1rs_sync2.sv */
// two flip-flop synchroniser for a group of pin inputs
module e1rs_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinSync
);
    logic [WIDTH-1:0] stage_r;

    // =================================================================
    // first stage is read only by the second
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            stage_r <= '1;
            pinSync <= '1;
        end else begin
            stage_r <= pinIn;
            pinSync <= stage_r;
        end
    end
endmodule : e1rs_sync2
